// ### logic/gps_port.sv
/*
 * three 8-bit general-purpose ports (a, b, c) with direction, latch,
 * pin-level, analog-select and weak pull-up registers, plus a steering
 * register moving slave select and capture/compare unit two between pins.
 * assumes a single clock, pad inputs asynchronous to it, peripherals
 * synchronous to it, and a plain strobe register port.
 */
`include "gps_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module gps_port (
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	input  wire gps_pkg::gps_addr_t addr_i,
	input  wire gps_pkg::gps_byte_t wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output var  gps_pkg::gps_byte_t rdata_o,
	input  wire gps_pkg::gps_pins_t pad_in_i,
	output var  gps_pkg::gps_pins_t pad_out_o,
	output var  gps_pkg::gps_pins_t pad_oe_o,
	output var  gps_pkg::gps_pins_t pullup_en_o,
	output var  gps_pkg::gps_pins_t in_buf_dis_o,
	input  wire gps_pkg::gps_pins_t periph_en_i,
	input  wire gps_pkg::gps_pins_t periph_out_i,
	input  wire gps_pkg::gps_pins_t periph_oe_i,
	input  wire logic              cc2_en_i,
	input  wire logic              cc2_out_i,
	input  wire logic              cc2_oe_i,
	output var  logic              cc2_in_o,
	output var  logic              slave_sel_o,
	output var  gps_pkg::gps_pins_t pin_level_o
);
	import gps_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// register state

	gps_pins_t dir_q;
	gps_pins_t latch_q;
	gps_pins_t analog_q;
	gps_pins_t pullup_q;
	logic [1:0] steer_q;
	gps_pins_t sync1_q;
	gps_pins_t sync2_q;
	gps_pins_t pin_lvl;
	gps_pins_t out_d;
	gps_pins_t oe_d;
	gps_byte_t rdata_d;
	gps_port_t port_sel;
	logic [2:0] kind_sel;
	logic [4:0] cc2_pin;
	logic       wr_pin;
	logic       wr_latch;
	logic       wr_dir;
	logic       wr_analog;
	logic       wr_pullup;
	logic       wr_steer;

	function automatic gps_port_t port_of(input gps_addr_t a);
		case (a[4:3])
			2'h0: port_of = GPS_PORT_A;
			2'h1: port_of = GPS_PORT_B;
			2'h2: port_of = GPS_PORT_C;
			default: port_of = GPS_PORT_NONE;
		endcase
	endfunction

	function automatic gps_byte_t slice(input gps_pins_t v,
	                                    input gps_port_t p);
		case (p)
			GPS_PORT_A: slice = v[7:0];
			GPS_PORT_B: slice = v[15:8];
			GPS_PORT_C: slice = v[23:16];
			default:    slice = 8'h00;
		endcase
	endfunction

	function automatic gps_pins_t put(input gps_pins_t v,
	                                  input gps_port_t p,
	                                  input gps_byte_t b);
		put = v;
		case (p)
			GPS_PORT_A: put[7:0] = b;
			GPS_PORT_B: put[15:8] = b;
			GPS_PORT_C: put[23:16] = b;
			default:    put = v;
		endcase
	endfunction

	assign port_sel = port_of(addr_i);
	assign kind_sel = addr_i[2:0];

	////////////////////////////////////////////////////////////////////////
	// strobe decode; a frozen clock enable masks every strobe

	function automatic logic kind_hit(input logic       strobe,
	                                  input logic [2:0] kind,
	                                  input logic [2:0] want);
		kind_hit = strobe && (kind == want);
	endfunction

	assign wr_pin    = kind_hit(ce_i && wr_i, kind_sel, `GPS_KIND_PIN);
	assign wr_latch  = kind_hit(ce_i && wr_i, kind_sel, `GPS_KIND_LATCH);
	assign wr_dir    = kind_hit(ce_i && wr_i, kind_sel, `GPS_KIND_DIR);
	assign wr_analog = kind_hit(ce_i && wr_i, kind_sel, `GPS_KIND_ANALOG);
	assign wr_pullup = kind_hit(ce_i && wr_i, kind_sel, `GPS_KIND_PULLUP);
	// steering sits outside the port decode, so it needs the full address
	assign wr_steer  = ce_i && wr_i && (addr_i == `GPS_ADDR_STEER);

	////////////////////////////////////////////////////////////////////////
	// pad synchroniser; first stage feeds only the second

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q <= 24'h000000;
			sync2_q <= 24'h000000;
		end else if (ce_i) begin
			sync1_q <= pad_in_i;
			sync2_q <= sync1_q;
		end
	end

	// analog pins read zero since the input buffer is off
	assign pin_lvl = sync2_q & ~analog_q;

	////////////////////////////////////////////////////////////////////////
	// software writes

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			latch_q <= {`GPS_NUM_PORTS{`GPS_RST_LATCH}};
		end else if (wr_pin || wr_latch) begin
			latch_q <= put(latch_q, port_sel, wdata_i);
		end
	end

	// steering writes never reach this block
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dir_q <= {`GPS_NUM_PORTS{`GPS_RST_DIR}};
		end else if (wr_dir) begin
			dir_q <= put(dir_q, port_sel, wdata_i);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			analog_q <= {`GPS_NUM_PORTS{`GPS_RST_ANALOG}};
		end else if (wr_analog) begin
			analog_q <= put(analog_q, port_sel, wdata_i);
		end
	end

	// pull-ups stay under software control even on analog pins
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pullup_q <= {`GPS_NUM_PORTS{`GPS_RST_PULLUP}};
		end else if (wr_pullup) begin
			pullup_q <= put(pullup_q, port_sel, wdata_i);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			steer_q <= `GPS_RST_STEER;
		end else if (wr_steer) begin
			steer_q <= wdata_i[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path, data valid only in the cycle after the strobe

	always_comb begin
		rdata_d = 8'h00;
		if (addr_i == `GPS_ADDR_STEER) begin
			rdata_d = {6'h00, steer_q};
		end else begin
			case (kind_sel)
				`GPS_KIND_PIN:    rdata_d = slice(pin_lvl, port_sel);
				`GPS_KIND_LATCH:  rdata_d = slice(latch_q, port_sel);
				`GPS_KIND_DIR:    rdata_d = slice(dir_q, port_sel);
				`GPS_KIND_ANALOG: rdata_d = slice(analog_q, port_sel);
				`GPS_KIND_PULLUP: rdata_d = slice(pullup_q, port_sel);
				default:          rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
		end else if (ce_i) begin
			rdata_o <= rd_i ? rdata_d : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output priority: dedicated peripheral, then capture two, then latch

	assign cc2_pin = steer_q[`GPS_STEER_CC2_BIT] ?
	                 5'(`GPS_PIN_B3) : 5'(`GPS_PIN_C1);

	always_comb begin
		out_d = latch_q;
		oe_d = ~dir_q;
		for (int i = 0; i < 24; i++) begin
			// only the steered pin is overridden
			if (cc2_en_i && 5'(i) == cc2_pin) begin
				out_d[i] = cc2_out_i;
				oe_d[i] = cc2_oe_i;
			end
			if (periph_en_i[i]) begin
				out_d[i] = periph_out_i[i];
				oe_d[i] = periph_oe_i[i];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pad_out_o <= {`GPS_NUM_PORTS{`GPS_RST_LATCH}};
			pad_oe_o <= 24'h000000;
			pullup_en_o <= {`GPS_NUM_PORTS{`GPS_RST_PULLUP}};
			in_buf_dis_o <= {`GPS_NUM_PORTS{`GPS_RST_ANALOG}};
		end else if (ce_i) begin
			pad_out_o <= out_d;
			pad_oe_o <= oe_d;
			pullup_en_o <= pullup_q;
			in_buf_dis_o <= analog_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// steered inputs; pin stays readable while a peripheral owns it

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			slave_sel_o <= 1'b0;
			cc2_in_o <= 1'b0;
			pin_level_o <= 24'h000000;
		end else if (ce_i) begin
			slave_sel_o <= steer_q[`GPS_STEER_SS_BIT] ?
			               pin_lvl[`GPS_PIN_A0] :
			               pin_lvl[`GPS_PIN_A5];
			cc2_in_o <= pin_lvl[cc2_pin];
			pin_level_o <= pin_lvl;
		end
	end

endmodule
`default_nettype wire

// ### logic/gps_defs.svh
/*
 * constants for the pin-steering I/O port: register map, field positions,
 * reset values. assumes nothing beyond being included by its bare name.
 */
`ifndef GPS_DEFS_SVH
`define GPS_DEFS_SVH

`define GPS_ADDR_W        5
`define GPS_NUM_PORTS     3
// register kind within a port, address bits [2:0]
`define GPS_KIND_PIN      3'h0
`define GPS_KIND_LATCH    3'h1
`define GPS_KIND_DIR      3'h2
`define GPS_KIND_ANALOG   3'h3
`define GPS_KIND_PULLUP   3'h4
// steering register address
`define GPS_ADDR_STEER    5'h18
// steering fields
`define GPS_STEER_CC2_BIT 0
`define GPS_STEER_SS_BIT  1
// pin indices inside the 24-bit pin vector
`define GPS_PIN_A0        0
`define GPS_PIN_A5        5
`define GPS_PIN_B3        11
`define GPS_PIN_C1        17
// reset values
`define GPS_RST_DIR       8'hff
`define GPS_RST_LATCH     8'h00
`define GPS_RST_ANALOG    8'hff
`define GPS_RST_PULLUP    8'h00
`define GPS_RST_STEER     2'h0

`endif

// ### logic/gps_pkg.sv
/*
 * types shared by the pin-steering I/O port.
 * assumes gps_defs.svh is on the include path.
 */
`default_nettype none
package gps_pkg;
	typedef logic [7:0] gps_byte_t;
	typedef logic [4:0] gps_addr_t;
	typedef logic [23:0] gps_pins_t;
	typedef enum logic [1:0] {
		GPS_PORT_A,
		GPS_PORT_B,
		GPS_PORT_C,
		GPS_PORT_NONE
	} gps_port_t;
endpackage
`default_nettype wire

// ### verification/gps_port_asserts.sv
/* port checker bound to gps_port. assumes one clock, async low reset. */
`timescale 1ns/1ns
`default_nettype none
module gps_port_asserts (
	input wire logic               clk_i,
	input wire logic               rst_n_i,
	input wire logic               ce_i,
	input wire gps_pkg::gps_addr_t addr_i,
	input wire gps_pkg::gps_byte_t wdata_i,
	input wire logic               wr_i,
	input wire logic               rd_i,
	input wire gps_pkg::gps_byte_t rdata_o,
	input wire gps_pkg::gps_pins_t pad_out_o,
	input wire gps_pkg::gps_pins_t pad_oe_o,
	input wire gps_pkg::gps_pins_t in_buf_dis_o,
	input wire gps_pkg::gps_pins_t periph_en_i,
	input wire gps_pkg::gps_pins_t periph_out_i,
	input wire gps_pkg::gps_pins_t periph_oe_i,
	input wire logic               cc2_en_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////
	steer_read_a: assert property (ce_i && rd_i && addr_i == 5'h18
		|=> rdata_o[7:2] == 6'h00) else $error("steering top bits set");
	unmapped_rd_a: assert property (ce_i && rd_i && addr_i[2:0] > 3'h4
		|=> rdata_o == 8'h00) else $error("unmapped read not zero");
	rdata_idle_a: assert property (ce_i && !rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read slot");
	latch_out_a: assert property (wr_i && ce_i && addr_i[4:1] == 4'h0
		##1 ce_i && periph_en_i[7:0] == 8'h00
		|=> ((pad_out_o[7:0] ^ $past(wdata_i, 2)) & pad_oe_o[7:0]) == 8'h00)
		else $error("latch write not on pads");
	dir_oe_a: assert property (wr_i && ce_i && addr_i == 5'h02
		##1 ce_i && periph_en_i[7:0] == 8'h00
		|=> pad_oe_o[7:0] == ~$past(wdata_i, 2)) else $error("direction wrong");
	analog_buf_a: assert property (wr_i && ce_i && addr_i == 5'h03
		##1 ce_i |=> in_buf_dis_o[7:0] == $past(wdata_i, 2))
		else $error("input buffer disable wrong");
	periph_prio_a: assert property (ce_i |=> (((pad_out_o ^
		$past(periph_out_i)) | (pad_oe_o ^ $past(periph_oe_i)))
		& $past(periph_en_i)) == 24'h0) else $error("peripheral lost pin");
	analog_mask_a: assert property (ce_i && rd_i && addr_i == 5'h00
		|=> ({16'h0, rdata_o} & in_buf_dis_o) == 24'h0)
		else $error("analog pin read nonzero");
	cover property (rd_i && addr_i == 5'h18);
	cover property (cc2_en_i && wr_i);
	cover property (|periph_en_i);
endmodule
bind gps_port gps_port_asserts u_chk (.clk_i, .rst_n_i, .ce_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .pad_out_o, .pad_oe_o, .in_buf_dis_o,
	.periph_en_i, .periph_out_i, .periph_oe_i, .cc2_en_i);
`default_nettype wire

// ### verification/gps_pad_model.sv
/* pad wires outside the port. assumes the bench drives the external level. */
`timescale 1ns/1ns
`default_nettype none
module gps_pad_model (
	input  wire logic               clk_i,
	input  wire gps_pkg::gps_pins_t out_i,
	input  wire gps_pkg::gps_pins_t oe_i,
	input  wire gps_pkg::gps_pins_t pu_i,
	input  wire gps_pkg::gps_pins_t ext_i,
	input  wire gps_pkg::gps_pins_t ext_en_i,
	output var  gps_pkg::gps_pins_t pad_o
);
	logic tog_q = 1'b0;
	// undriven pins without pull-up wobble so stale values never match
	always_ff @(posedge clk_i) begin
		tog_q <= ~tog_q;
	end
	always_comb begin
		pad_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i)
			| (~oe_i & ~ext_en_i & (pu_i | {24{tog_q}}));
	end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
/* self-checking bench for gps_port. assumes gps_defs.svh on include path. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import gps_pkg::*;
	logic      clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
	logic      wr_i = 1'b0, rd_i = 1'b0, cc2_in_o, slave_sel_o;
	logic      cc2_en_i = 1'b0, cc2_out_i = 1'b0, cc2_oe_i = 1'b0;
	gps_addr_t addr_i = 5'h00;
	gps_byte_t wdata_i = 8'h00, rdata_o;
	gps_pins_t pad, pad_out_o, pad_oe_o, pullup_en_o, in_buf_dis_o;
	gps_pins_t pin_level_o, ext = 24'h0;
	gps_pins_t periph_en_i = 24'h0, periph_out_i = 24'h0, periph_oe_i = 24'h0;
	int        error_cnt = 0, check_count = 0;
	always #2 clk_i = ~clk_i;
	gps_port u_dut (.clk_i, .rst_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .pad_in_i(pad), .pad_out_o, .pad_oe_o, .pullup_en_o,
		.in_buf_dis_o, .periph_en_i, .periph_out_i, .periph_oe_i, .cc2_en_i,
		.cc2_out_i, .cc2_oe_i, .cc2_in_o, .slave_sel_o, .pin_level_o);
	gps_pad_model u_pads (.clk_i, .out_i(pad_out_o), .oe_i(pad_oe_o),
		.pu_i(pullup_en_o), .ext_i(ext), .ext_en_i(24'hffffff), .pad_o(pad));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input gps_pins_t got, input gps_pins_t exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input gps_addr_t a, input gps_byte_t d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rdc(input gps_addr_t a, input gps_byte_t e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk({16'h0, rdata_o}, {16'h0, e});
	endtask
	task automatic gap;
		repeat (5) @(posedge clk_i);
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int p = 0; p < 3; p++) begin
			rdc({p[1:0], 3'h1}, 8'h00);
			rdc({p[1:0], 3'h2}, 8'hff);
			rdc({p[1:0], 3'h3}, 8'hff);
			rdc({p[1:0], 3'h4}, 8'h00);
		end
		rdc(5'h18, 8'h00);
		rdc(5'h07, 8'h00);
	endtask
	task automatic t_latch;
		wr(5'h03, 8'h00);
		wr(5'h00, 8'ha5);
		rdc(5'h01, 8'ha5);
		wr(5'h01, 8'h3c);
		wr(5'h02, 8'h00);
		wr(5'h04, 8'hf0);
		gap;
		rdc(5'h00, 8'h3c);
		chk(pullup_en_o, 24'h0000f0);
		wr(5'h02, 8'hff);
		ext <= 24'h000096;
		gap;
		rdc(5'h00, 8'h96);
		chk(pin_level_o, 24'h000096);
		rdc(5'h01, 8'h3c);
	endtask
	task automatic t_analog;
		wr(5'h03, 8'h0f);
		ext <= 24'h0000ff;
		gap;
		rdc(5'h00, 8'hf0);
		chk(in_buf_dis_o, 24'hffff0f);
	endtask
	task automatic t_steer;
		wr(5'h03, 8'h00);
		wr(5'h13, 8'h00);
		ext <= 24'h000001;
		wr(5'h18, 8'hff);
		rdc(5'h18, 8'h03);
		rdc(5'h02, 8'hff);
		gap;
		chk({23'h0, slave_sel_o}, 24'h1);
		cc2_en_i <= 1'b1;
		cc2_oe_i <= 1'b1;
		cc2_out_i <= 1'b1;
		wr(5'h18, 8'h01);
		gap;
		chk({23'h0, slave_sel_o}, 24'h0);
		chk({22'h0, pad_oe_o[17], pad_oe_o[11]}, 24'h1);
		rdc(5'h0a, 8'hff);
		wr(5'h18, 8'h00);
		gap;
		chk({22'h0, pad_oe_o[17], pad_oe_o[11]}, 24'h2);
		chk({23'h0, cc2_in_o}, 24'h1);
	endtask
	task automatic t_periph;
		wr(5'h01, 8'h00);
		wr(5'h02, 8'h00);
		periph_en_i <= 24'h000004;
		periph_out_i <= 24'h000004;
		periph_oe_i <= 24'h000004;
		gap;
		chk({16'h0, pad_out_o[7:0]}, 24'h000004);
		rdc(5'h00, 8'h04);
	endtask
	task automatic t_freeze;
		ce_i <= 1'b0;
		wr(5'h01, 8'hff);
		ce_i <= 1'b1;
		rdc(5'h01, 8'h00);
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset;
		t_latch;
		t_analog;
		t_steer;
		t_periph;
		t_freeze;
		summarize;
	end
	initial begin
		#20000;
		error_cnt++;
		summarize;
	end
endmodule
`default_nettype wire
